// >>> rtl/its_map.svh
`ifndef ITS_MAP_SVH
`define ITS_MAP_SVH

// Register byte offsets on the APB slave.
`define ITS_A_CTRL      8'h00
`define ITS_A_DURATION  8'h04
`define ITS_A_DELAY     8'h08
`define ITS_A_UPPER     8'h0c
`define ITS_A_LOWER     8'h10
`define ITS_A_CMD       8'h14
`define ITS_A_STATUS    8'h18
`define ITS_A_ELAPSED   8'h1c
`define ITS_A_MEAS      8'h20

// Register widths and reset values.
`define ITS_CTRL_W      11
`define ITS_CTRL_RST    11'h080
`define ITS_MS_W        24
`define ITS_DLY_W       16
`define ITS_RES_W       22
`define ITS_STAT_W      7
`define ITS_DISP_W      14

// Command register bit positions.
`define ITS_CMD_START   0
`define ITS_CMD_STOP    1

// Pin vector bit positions.
`define ITS_P_VSTABLE   0
`define ITS_P_KSTART    1
`define ITS_P_KSTOP     2
`define ITS_P_XSTART    3
`define ITS_P_XSTOP_N   4
`define ITS_P_PROBE     5
`define ITS_PINS        6

// Times in milliseconds.
`define ITS_FAST_MS     30
`define ITS_CHECK_MS    100
`define ITS_SLOW_MS     500
`define ITS_LAMP_MS     250
`define ITS_TENTH_MS    100
`define ITS_MS_PER_S    1000

// Limits: 4000 megohm in kilohm steps, elapsed display 999.9 s in tenths.
`define ITS_LIMIT_MAX   22'h3d0900
`define ITS_DISP_MAX    14'h270f

`endif

// >>> rtl/its_pkg.sv
package its_pkg;

  typedef enum logic [1:0] {
    ITS_MODE_CONTINUOUS_MODE,
    ITS_MODE_PASS_STOP,
    ITS_MODE_FAIL_STOP,
    ITS_MODE_FORCED_END
  } its_mode_e;

  typedef enum logic [1:0] {
    ITS_BUZZ_OFF,
    ITS_BUZZ_PASS,
    ITS_BUZZ_FAIL,
    ITS_BUZZ_END
  } its_buzz_e;

  typedef enum logic [1:0] {
    ITS_IDLE,
    ITS_DELAY,
    ITS_MEASURE
  } its_state_e;

  // Control word, first field in the highest bits.
  typedef struct packed {
    logic      interlock_en;
    logic      lower_en;
    logic      upper_en;
    its_buzz_e buzz;
    its_mode_e mode;
    logic      delay_auto;
    logic      timer_on;
    logic      contact_chk;
    logic      speed_slow;
  } its_cfg_s;

  typedef struct packed {
    logic upper_fail;
    logic lower_fail;
    logic pass;
  } its_judge_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } its_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } its_apb_rsp_s;

endpackage

// >>> rtl/its_sequencer.sv
`timescale 1ns/1ps

`include "its_map.svh"

// The accuracy ceiling is a parameter so a bench can lower it below the largest
// writable limit; at its default no writable limit pair can exceed it.
module its_sequencer #(
  parameter int unsigned CLK_HZ     = 25_000_000,
  parameter int unsigned MS_CYC     = CLK_HZ / `ITS_MS_PER_S,
  parameter logic [21:0] ACC_MAX    = `ITS_LIMIT_MAX
) (
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  input  wire logic                      clk_en,
  input  wire its_pkg::its_apb_req_s     apb_req,
  output its_pkg::its_apb_rsp_s          apb_rsp,
  input  wire logic                      key_start,
  input  wire logic                      key_stop,
  input  wire logic                      ext_start,
  input  wire logic                      ext_stop_n,
  input  wire logic                      probe_sw,
  input  wire logic                      vout_stable,
  input  wire logic [`ITS_RES_W-1:0]     meas_kohm,
  output logic                           test_volt_en,
  output logic                           delay_ind,
  output logic                           test_lamp,
  output logic                           meas_valid,
  output logic [`ITS_RES_W-1:0]          meas_disp,
  output its_pkg::its_judge_s            judge,
  output logic                           judge_stb,
  output logic                           buzz_pulse,
  output logic [`ITS_DISP_W-1:0]         time_disp
);
  import its_pkg::*;

  localparam int unsigned MS_W = $clog2(MS_CYC + 1);

  // Slow speed wins over the contact check, which only stretches the fast period.
  // All periods are counted in whole milliseconds of the restarted time base.
  function automatic logic [`ITS_MS_W-1:0] period_ms(input logic slow, input logic chk);
    if (slow) begin
      period_ms = `ITS_MS_W'(`ITS_SLOW_MS);
    end else if (chk) begin
      period_ms = `ITS_MS_W'(`ITS_CHECK_MS);
    end else begin
      period_ms = `ITS_MS_W'(`ITS_FAST_MS);
    end
  endfunction

  // A disabled limit never raises its flag, and pass needs at least one limit.
  // Two enabled limits that both lie beyond the accuracy ceiling force both fail flags so the result is never a pass.
  function automatic its_judge_s judge_of(input logic [`ITS_RES_W-1:0] v, input its_cfg_s c,
                                          input logic [`ITS_RES_W-1:0] up,
                                          input logic [`ITS_RES_W-1:0] lo);
    its_judge_s j;
    j.upper_fail = c.upper_en && (v >= up);
    j.lower_fail = c.lower_en && (v <= lo);
    if (c.upper_en && c.lower_en && up > ACC_MAX && lo > ACC_MAX) begin
      j.upper_fail = 1'b1;
      j.lower_fail = 1'b1;
    end
    j.pass = (c.upper_en || c.lower_en) && !j.upper_fail && !j.lower_fail;
    return j;
  endfunction

  its_cfg_s                 cfg;
  logic [`ITS_MS_W-1:0]     duration_ms;
  logic [`ITS_DLY_W-1:0]    delay_ms;
  logic [`ITS_RES_W-1:0]    upper_lim;
  logic [`ITS_RES_W-1:0]    lower_lim;
  logic                     cmd_start;
  logic                     cmd_stop;
  logic [31:0]              rdata;
  its_state_e               state;
  its_state_e               next_state;
  logic [`ITS_PINS-1:0]     pin_s1;
  logic [`ITS_PINS-1:0]     pin_s2;
  logic [`ITS_PINS-1:0]     pin_s3;
  logic [MS_W-1:0]          cyc_cnt;
  logic [`ITS_MS_W-1:0]     elapsed_ms;
  logic [`ITS_MS_W-1:0]     per_ms;
  logic [`ITS_MS_W-1:0]     lamp_ms;
  logic [`ITS_MS_W-1:0]     tenth_ms;
  its_judge_s               last_j;
  logic                     have_j;

  // Bus decode.
  wire apb_setup  = apb_req.psel && !apb_req.penable;
  wire apb_access = apb_req.psel && apb_req.penable;
  wire a_ctrl     = apb_req.paddr == `ITS_A_CTRL;
  wire a_dur      = apb_req.paddr == `ITS_A_DURATION;
  wire a_dly      = apb_req.paddr == `ITS_A_DELAY;
  wire a_up       = apb_req.paddr == `ITS_A_UPPER;
  wire a_lo       = apb_req.paddr == `ITS_A_LOWER;
  wire a_cmd      = apb_req.paddr == `ITS_A_CMD;
  wire a_stat     = apb_req.paddr == `ITS_A_STATUS;
  wire a_elap     = apb_req.paddr == `ITS_A_ELAPSED;
  wire a_meas     = apb_req.paddr == `ITS_A_MEAS;
  wire a_hit      = a_ctrl | a_dur | a_dly | a_up | a_lo | a_cmd | a_stat | a_elap | a_meas;
  wire wr_en      = apb_access && apb_req.pwrite && a_hit && clk_en;
  wire [`ITS_RES_W-1:0] wr_lim = apb_req.pwdata[`ITS_RES_W-1:0];
  wire lim_ok     = wr_lim <= `ITS_LIMIT_MAX;

  assign apb_rsp.pready  = apb_access;
  assign apb_rsp.pslverr = apb_access && !a_hit;
  assign apb_rsp.prdata  = rdata;

  wire running     = state != ITS_IDLE;
  wire [`ITS_STAT_W-1:0] status = {test_lamp, meas_valid, judge.pass, judge.lower_fail,
                                   judge.upper_fail, delay_ind, running};
  wire [`ITS_MS_W-1:0] remain_ms = (elapsed_ms >= duration_ms) ? '0 : duration_ms - elapsed_ms;

  wire [31:0] next_rdata =
    a_ctrl ? 32'(cfg) :
    a_dur  ? 32'(duration_ms) :
    a_dly  ? 32'(delay_ms) :
    a_up   ? 32'(upper_lim) :
    a_lo   ? 32'(lower_lim) :
    a_stat ? 32'(status) :
    a_elap ? (cfg.timer_on ? 32'(remain_ms) : 32'(elapsed_ms)) :
    a_meas ? 32'(meas_disp) : 32'h0000_0000;

  // Read data is captured in the setup cycle so the answer comes from a flop.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h0000_0000;
    end else if (clk_en && apb_setup) begin
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg         <= its_cfg_s'(`ITS_CTRL_RST);
      duration_ms <= '0;
      delay_ms    <= '0;
      upper_lim   <= '0;
      lower_lim   <= '0;
    end else if (wr_en) begin
      if (a_ctrl) cfg <= its_cfg_s'(apb_req.pwdata[`ITS_CTRL_W-1:0]);
      if (a_dur) duration_ms <= apb_req.pwdata[`ITS_MS_W-1:0];
      if (a_dly) delay_ms <= apb_req.pwdata[`ITS_DLY_W-1:0];
      if (a_up && lim_ok) upper_lim <= wr_lim;
      if (a_lo && lim_ok) lower_lim <= wr_lim;
    end
  end

  // Serial start and stop commands last one enabled cycle.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_start <= 1'b0;
      cmd_stop  <= 1'b0;
    end else if (clk_en) begin
      cmd_start <= wr_en && a_cmd && apb_req.pwdata[`ITS_CMD_START];
      cmd_stop  <= wr_en && a_cmd && apb_req.pwdata[`ITS_CMD_STOP];
    end
  end

  // Pins pass two flops; the third flop only serves edge detection.
  wire [`ITS_PINS-1:0] pins = {probe_sw, ext_stop_n, ext_start, key_stop, key_start, vout_stable};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else if (clk_en) begin
      pin_s1 <= pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Edges are taken between the second and third flop, so a pin change acts
  // three edges after it arrives; pulses shorter than a clock may be missed.
  wire [`ITS_PINS-1:0] pin_rise = pin_s2 & ~pin_s3;
  wire [`ITS_PINS-1:0] pin_fall = ~pin_s2 & pin_s3;

  // any source may start or stop
  wire start_evt = pin_rise[`ITS_P_KSTART] | pin_rise[`ITS_P_XSTART] | pin_rise[`ITS_P_PROBE] | cmd_start;
  wire stop_evt  = pin_rise[`ITS_P_KSTOP] | ~pin_s2[`ITS_P_XSTOP_N] | pin_fall[`ITS_P_PROBE] | cmd_stop;
  // interlock blocks start
  // The stop input acts as a level, so a start that meets it is dropped, not queued.
  wire start_ok  = start_evt && pin_s2[`ITS_P_XSTOP_N] && !cfg.interlock_en;

  // Millisecond time base, restarted at each accepted start.
  wire ms_tick = running && (cyc_cnt == MS_W'(MS_CYC - 1));

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_cnt <= '0;
    end else if (clk_en) begin
      cyc_cnt <= (!running || ms_tick) ? '0 : cyc_cnt + 1'b1;
    end
  end

  wire [`ITS_MS_W-1:0] period = period_ms(cfg.speed_slow, cfg.contact_chk);
  // a sample only after a full period
  wire sample_take = (state == ITS_MEASURE) && ms_tick && (per_ms == period - 1'b1);
  // The judgment is combinational on the live reading; it only counts on a sample cycle.
  its_judge_s cur_j;
  assign cur_j = judge_of(meas_kohm, cfg, upper_lim, lower_lim);

  // duration bound when timer is on
  // timer off runs until stop or a pass/fail stop mode hit
  // Elapsed time starts at the accepted start, so the response time eats into the duration.
  wire dur_done = cfg.timer_on && (elapsed_ms >= duration_ms);
  // automatic delay waits for stable output
  // manual delay waits only for time
  wire dly_done = cfg.delay_auto ? pin_s2[`ITS_P_VSTABLE] : (elapsed_ms >= `ITS_MS_W'(delay_ms));
  wire mode_hit = sample_take &&
                  (((cfg.mode == ITS_MODE_PASS_STOP) && cur_j.pass) ||
                   ((cfg.mode == ITS_MODE_FAIL_STOP) && (cur_j.upper_fail || cur_j.lower_fail)));
  // end on duration, stop or a pass/fail stop mode hit
  wire end_now  = running && (stop_evt || dur_done || mode_hit);
  wire forced   = cfg.mode == ITS_MODE_FORCED_END;
  // continuous and stop modes publish every sample
  // Forced end publishes only if some sample exists; a test cut in the delay stays silent.
  wire pub_now  = (sample_take && !forced) || (end_now && forced && (have_j || sample_take));
  its_judge_s pub_j;
  assign pub_j = sample_take ? cur_j : last_j;

  always_comb begin
    next_state = state;
    unique case (state)
      ITS_IDLE: begin
        if (start_ok) next_state = ITS_DELAY;
      end
      ITS_DELAY: begin
        if (end_now) next_state = ITS_IDLE;
        else if (dly_done) next_state = ITS_MEASURE;
      end
      ITS_MEASURE: begin
        if (end_now) next_state = ITS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ITS_IDLE;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // voltage enable follows the running state
  assign test_volt_en = running;
  assign delay_ind    = state == ITS_DELAY;

  // Time keeping: elapsed ms, sample period, lamp and tenths display.
  // Elapsed ms saturates at all ones so a very long untimed test cannot wrap
  // its elapsed readback back to zero; the duration compare is gated off by timer_on.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      elapsed_ms <= '0;
      per_ms     <= '0;
      lamp_ms    <= '0;
      tenth_ms   <= '0;
      time_disp  <= '0;
      test_lamp  <= 1'b0;
    end else if (clk_en) begin
      if (start_ok && !running) begin
        elapsed_ms <= '0;
        per_ms     <= '0;
        lamp_ms    <= '0;
        tenth_ms   <= '0;
        time_disp  <= '0;
        test_lamp  <= 1'b1;
      end else if (!running) begin
        test_lamp  <= 1'b0;
      end else if (ms_tick) begin
        if (elapsed_ms != '1) elapsed_ms <= elapsed_ms + 1'b1;
        per_ms <= (state != ITS_MEASURE || sample_take) ? '0 : per_ms + 1'b1;
        if (lamp_ms == `ITS_MS_W'(`ITS_LAMP_MS - 1)) begin
          lamp_ms   <= '0;
          test_lamp <= ~test_lamp;
        end else begin
          lamp_ms <= lamp_ms + 1'b1;
        end
        if (tenth_ms == `ITS_MS_W'(`ITS_TENTH_MS - 1)) begin
          tenth_ms <= '0;
          if (time_disp != `ITS_DISP_MAX) time_disp <= time_disp + 1'b1;
        end else begin
          tenth_ms <= tenth_ms + 1'b1;
        end
      end
      if (end_now) test_lamp <= 1'b0;
    end
  end

  // Measurement display and judgments; the last result stays after the end.
  // Keeping the result lets the operator read it once the voltage is off.
  // The strobe and buzzer pulses last one enabled cycle each.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meas_valid <= 1'b0;
      meas_disp  <= '0;
      last_j     <= '0;
      have_j     <= 1'b0;
      judge      <= '0;
      judge_stb  <= 1'b0;
      buzz_pulse <= 1'b0;
    end else if (clk_en) begin
      judge_stb  <= 1'b0;
      buzz_pulse <= 1'b0;
      if (start_ok && !running) begin
        // blank display, no judgment during delay
        meas_valid <= 1'b0;
        have_j     <= 1'b0;
        judge      <= '0;
      end else begin
        if (sample_take) begin
          meas_disp  <= meas_kohm;
          meas_valid <= 1'b1;
          // both out of range fail together
          last_j     <= cur_j;
          have_j     <= 1'b1;
        end
        if (pub_now && (cfg.upper_en || cfg.lower_en)) begin
          judge     <= pub_j;
          judge_stb <= 1'b1;
        end
        // The end condition sounds on any termination, even one without a judgment.
        // buzzer conditions
        buzz_pulse <= (pub_now && cfg.buzz == ITS_BUZZ_PASS && pub_j.pass) ||
                      (pub_now && cfg.buzz == ITS_BUZZ_FAIL && (pub_j.upper_fail || pub_j.lower_fail)) ||
                      (end_now && cfg.buzz == ITS_BUZZ_END);
      end
    end
  end

endmodule // its_sequencer

// >>> verif/its_eut_model.sv
`timescale 1ns/1ps
`include "its_map.svh"

module its_eut_model #(
  parameter int RISE = 800
) (
  input  wire logic                  core_clk,
  input  wire logic                  test_volt_en,
  input  wire logic [`ITS_RES_W-1:0] kohm_set,
  output logic                       vout_stable,
  output logic [`ITS_RES_W-1:0]      meas_kohm
);
  int cnt = 0;

  // A capacitive load needs RISE cycles of applied voltage before it settles.
  always @(posedge core_clk) begin
    cnt <= test_volt_en ? cnt + int'(cnt < RISE) : 0;
  end
  assign vout_stable = (cnt >= RISE);
  // Without voltage the reading is meaningless, so it never repeats the last value.
  assign meas_kohm = test_volt_en ? kohm_set : ~kohm_set;
endmodule // its_eut_model

// >>> verif/its_sequencer_props.sv
`timescale 1ns/1ps
`include "its_map.svh"

module its_sequencer_props
  import its_pkg::*;
#(
  parameter int unsigned MS_CYC = 25000
) (
  input wire logic                   core_clk,
  input wire logic                   arst_n,
  input wire logic                   clk_en,
  input wire logic                   ext_stop_n,
  input wire logic                   test_volt_en,
  input wire logic                   delay_ind,
  input wire logic                   test_lamp,
  input wire logic                   meas_valid,
  input wire its_pkg::its_judge_s    judge,
  input wire logic                   judge_stb,
  input wire logic                   buzz_pulse,
  input wire logic [`ITS_DISP_W-1:0] time_disp
);
  localparam int unsigned LAMP_CYC = 250 * MS_CYC;
  logic        lamp_q;
  int unsigned lamp_cnt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // Cycles since the lamp last changed while a test runs.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lamp_q   <= 1'b0;
      lamp_cnt <= 0;
    end else if (clk_en) begin
      lamp_q   <= test_lamp;
      lamp_cnt <= (!test_volt_en || test_lamp != lamp_q) ? 0 : lamp_cnt + 1;
    end
  end

  delay_in_test_a: assert property (delay_ind |-> test_volt_en)
    else $error("delay indicator without test voltage");
  delay_blank_a: assert property (delay_ind |-> !meas_valid && !judge_stb)
    else $error("value or judgment during response time");
  start_delay_a: assert property ($rose(test_volt_en) |-> delay_ind)
    else $error("test started without response time");
  stop_level_a: assert property ((!ext_stop_n && clk_en) [*5] |=> !test_volt_en)
    else $error("test runs while port stop is low");
  pass_excl_a: assert property (judge.pass |-> !judge.upper_fail && !judge.lower_fail)
    else $error("pass shown with a fail flag");
  stb_pulse_a: assert property (judge_stb |-> meas_valid ##1 !judge_stb)
    else $error("judgment strobe without sample or too long");
  buzz_once_a: assert property (buzz_pulse |=> !buzz_pulse)
    else $error("buzzer pulse longer than one cycle");
  time_sat_a: assert property (time_disp <= `ITS_DISP_MAX)
    else $error("elapsed display beyond saturation");
  lamp_idle_a: assert property (!test_volt_en [*2] |-> !test_lamp)
    else $error("test lamp lit while idle");
  lamp_rate_a: assert property (lamp_cnt <= LAMP_CYC + 3)
    else $error("test lamp stopped toggling");
  volt_end_a: assert property ($fell(test_volt_en) |-> !delay_ind)
    else $error("delay indicator outlives the test");

  cover property ($rose(judge_stb));
  cover property (judge.upper_fail && judge.lower_fail);
  cover property ($fell(delay_ind) && test_volt_en);
endmodule // its_sequencer_props

bind its_sequencer its_sequencer_props #(.MS_CYC(MS_CYC)) i_its_sequencer_props (
  .core_clk, .arst_n, .clk_en, .ext_stop_n, .test_volt_en, .delay_ind, .test_lamp,
  .meas_valid, .judge, .judge_stb, .buzz_pulse, .time_disp
);

// >>> verif/test_its_sequencer.sv
`timescale 1ns/1ps
`include "its_map.svh"

module test_its_sequencer;
  import its_pkg::*;
  localparam int MS = 10;
  logic core_clk = 0, arst_n = 0, key_start = 0, key_stop = 0, ext_start = 0, ext_stop_n = 1, probe_sw = 0;
  logic vout_stable, test_volt_en, delay_ind, test_lamp, meas_valid, judge_stb, buzz_pulse;
  logic [`ITS_RES_W-1:0]  kohm = '0, meas_kohm, meas_disp;
  logic [`ITS_DISP_W-1:0] time_disp;
  its_apb_req_s           req = '0;
  its_apb_rsp_s           rsp;
  its_judge_s             judge;
  int fail_count = 0, n_compared = 0, cyc = 0, n_stb, n_buzz, on_cyc, dly_cyc, meas_cyc;

  its_sequencer #(.MS_CYC(MS), .ACC_MAX(22'h2dc6c0)) i_its_sequencer (
    .core_clk, .arst_n, .clk_en(1'b1), .apb_req(req), .apb_rsp(rsp), .key_start, .key_stop,
    .ext_start, .ext_stop_n, .probe_sw, .vout_stable, .meas_kohm, .test_volt_en, .delay_ind,
    .test_lamp, .meas_valid, .meas_disp, .judge, .judge_stb, .buzz_pulse, .time_disp);
  its_eut_model #(.RISE(800)) i_its_eut_model (
    .core_clk, .test_volt_en, .kohm_set(kohm), .vout_stable, .meas_kohm);

  always #20 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (judge_stb === 1'b1) n_stb <= n_stb + 1;
    if (buzz_pulse === 1'b1) n_buzz <= n_buzz + 1;
    if (test_volt_en === 1'b1) on_cyc <= on_cyc + 1;
    if (delay_ind === 1'b1) dly_cyc <= dly_cyc + 1;
    if (test_volt_en === 1'b1 && delay_ind === 1'b0 && n_stb == 0) meas_cyc <= meas_cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    // The wait ends when pready is seen; only the bench cycle limit ends it if pready never comes.
    do begin
      @(posedge core_clk);
    end while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic setup(its_cfg_s c, int dur, int dly, int up, int lo, int k);
    wr(`ITS_A_CTRL, 32'(c));
    wr(`ITS_A_DURATION, dur);
    wr(`ITS_A_DELAY, dly);
    wr(`ITS_A_UPPER, up);
    wr(`ITS_A_LOWER, lo);
    kohm <= k[`ITS_RES_W-1:0];
    {n_stb, n_buzz, on_cyc, dly_cyc, meas_cyc} = '0;
  endtask

  // Pulses stay up for several cycles so the pin synchronisers see them.
  task automatic start(int src);
    case (src)
      0: wr(`ITS_A_CMD, 32'h1);
      1: key_start <= 1'b1;
      2: ext_start <= 1'b1;
      default: probe_sw <= 1'b1;
    endcase
    repeat (5) @(posedge core_clk);
    key_start <= 1'b0;
    ext_start <= 1'b0;
  endtask

  task automatic stop(int src);
    case (src)
      0: key_stop <= 1'b1;
      1: ext_stop_n <= 1'b0;
      default: wr(`ITS_A_CMD, 32'h2);
    endcase
    repeat (5) @(posedge core_clk);
    key_stop <= 1'b0;
    ext_stop_n <= 1'b1;
  endtask

  task automatic wait_v(logic v, int lim);
    int t = 0;
    while (test_volt_en !== v && t < lim) begin
      @(posedge core_clk);
      t++;
    end
    chk("test_volt_en", test_volt_en, v);
  endtask

  task automatic go(int src);
    start(src);
    wait_v(1'b1, 30);
    wait_v(1'b0, 20000);
    repeat (6) @(posedge core_clk);
    probe_sw <= 1'b0;
  endtask

  task automatic t_regs;
    logic [31:0] r;
    logic e;
    apb(1'b0, `ITS_A_CTRL, 0, r, e);
    chk("ctrl_reset", r, 32'h80);
    apb(1'b0, 8'h40, 0, r, e);
    chk("unmapped_err", e, 1);
    wr(`ITS_A_UPPER, 4000000);
    wr(`ITS_A_UPPER, 4000001);
    apb(1'b0, `ITS_A_UPPER, 0, r, e);
    chk("upper_max", r, 4000000);
  endtask

  task automatic t_continuous_mode;
    setup('{0, 1, 1, ITS_BUZZ_FAIL, ITS_MODE_CONTINUOUS_MODE, 0, 1, 0, 0}, 190, 50, 2000, 1000, 1500);
    go(0);
    chk("continuous_mode_stb", n_stb, 4);
    chk("continuous_mode_judge", judge, 3'b001);
    chk("continuous_mode_disp", meas_disp, 1500);
    chk("continuous_mode_on", on_cyc inside {[1895:1905]}, 1);
    chk("continuous_mode_delay", dly_cyc inside {[498:504]}, 1);
    chk("continuous_mode_buzz", n_buzz, 0);
  endtask

  task automatic t_speed;
    int p [4] = '{30, 100, 500, 500};
    for (int i = 0; i < 4; i++) begin
      setup('{0, 1, 1, ITS_BUZZ_PASS, ITS_MODE_PASS_STOP, 0, 0, i[0], i[1]}, 0, 20, 2000, 1000, 1500);
      go(i);
      chk("period", meas_cyc inside {[p[i] * MS - 3:p[i] * MS + 4]}, 1);
      chk("pass_stop", {n_stb[3:0], judge}, 7'h09);
      chk("buzz_pass", n_buzz, 1);
    end
  endtask

  task automatic t_fail;
    for (int i = 0; i < 2; i++) begin
      setup('{0, 1, 1, ITS_BUZZ_FAIL, ITS_MODE_FAIL_STOP, 0, 0, 0, 0}, 0, 20, 2000, 1000, i ? 1000 : 2000);
      go(0);
      chk("fail_stop", judge, i ? 3'b010 : 3'b100);
      chk("buzz_fail", n_buzz, 1);
    end
  endtask

  task automatic t_short;
    setup('{0, 1, 1, ITS_BUZZ_FAIL, ITS_MODE_CONTINUOUS_MODE, 0, 1, 0, 1}, 400, 10, 2000, 1000, 1500);
    go(0);
    chk("short_valid", {meas_valid, n_stb[3:0]}, 0);
  endtask

  task automatic t_auto;
    setup('{0, 1, 1, ITS_BUZZ_OFF, ITS_MODE_PASS_STOP, 1, 0, 0, 0}, 0, 10, 2000, 1000, 1500);
    go(0);
    chk("auto_delay", dly_cyc inside {[800:806]}, 1);
    chk("buzz_off", n_buzz, 0);
  endtask

  task automatic t_refuse;
    setup('{1, 1, 1, ITS_BUZZ_FAIL, ITS_MODE_CONTINUOUS_MODE, 0, 1, 0, 0}, 100, 10, 2000, 1000, 1500);
    start(0);
    repeat (30) @(posedge core_clk);
    chk("interlock", test_volt_en, 0);
    setup('{0, 1, 1, ITS_BUZZ_FAIL, ITS_MODE_CONTINUOUS_MODE, 0, 1, 0, 0}, 100, 10, 2000, 1000, 1500);
    ext_stop_n <= 1'b0;
    start(1);
    repeat (30) @(posedge core_clk);
    chk("stop_held", test_volt_en, 0);
    ext_stop_n <= 1'b1;
    repeat (5) @(posedge core_clk);
  endtask

  task automatic t_forced;
    for (int i = 0; i < 3; i++) begin
      setup('{0, 1, 1, ITS_BUZZ_END, ITS_MODE_FORCED_END, 0, 0, 0, 0}, 0, 20, 2000, 1000, 1500);
      start(i + 1);
      wait_v(1'b1, 30);
      repeat (1000) @(posedge core_clk);
      chk("forced_quiet", n_stb, 0);
      stop(i);
      wait_v(1'b0, 30);
      repeat (6) @(posedge core_clk);
      probe_sw <= 1'b0;
      chk("forced_one", {n_stb[3:0], judge}, 7'h09);
      chk("buzz_end", n_buzz, 1);
    end
  endtask

  task automatic t_lims;
    setup('{0, 0, 0, ITS_BUZZ_FAIL, ITS_MODE_CONTINUOUS_MODE, 0, 1, 0, 0}, 100, 10, 2000, 1000, 1500);
    go(0);
    chk("no_limits", {n_stb[3:0], judge}, 0);
    setup('{0, 1, 1, ITS_BUZZ_FAIL, ITS_MODE_CONTINUOUS_MODE, 0, 1, 0, 0}, 100, 10, 3500000, 3500000, 1500);
    go(0);
    chk("both_fail", judge, 3'b110);
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    t_regs();
    t_continuous_mode();
    t_speed();
    t_fail();
    t_short();
    t_auto();
    t_refuse();
    t_forced();
    t_lims();
    end_sim();
  end
endmodule // test_its_sequencer
